// *** verilog/lsw_pkg.sv ***
// constants, types and helpers shared by the latency stopwatch
package lsw_pkg;

  localparam logic [15:0] LSW_ADDR_CONTROL  = 16'h8040;
  localparam logic [15:0] LSW_ADDR_COUNT_HI = 16'h8041;
  localparam logic [15:0] LSW_ADDR_COUNT_LO = 16'h8042;
  localparam logic [15:0] LSW_ADDR_CLEAR    = 16'h0018;

  localparam logic [7:0]  LSW_CONTROL_RESET = 8'h00;
  localparam int          LSW_START_LSB     = 6;
  localparam int          LSW_DIV_LSB       = 4;
  localparam int          LSW_STOP_LSB      = 2;
  localparam int          LSW_ENABLE_BIT    = 1;
  localparam int          LSW_SOURCE_BIT    = 0;

  localparam logic [1:0]  LSW_SEL_LOW       = 2'h0;
  localparam logic [1:0]  LSW_SEL_HIGH      = 2'h1;

  localparam logic [19:0] LSW_COUNT_MAX     = 20'hFFFFF;
  localparam logic [19:0] LSW_COUNT_RESET   = 20'h00000;
  localparam logic [2:0]  LSW_DIV_RESET     = 3'h0;

  typedef enum logic [1:0] {
    LSW_IDLE = 2'h0,
    LSW_RUN  = 2'h1,
    LSW_DONE = 2'h3
  } lsw_state_e;

  // last value of the divide counter for a divide code
  function automatic logic [2:0] lsw_div_mask(input logic [1:0] div);
    case (div)
      2'h0:    lsw_div_mask = 3'h0;
      2'h1:    lsw_div_mask = 3'h1;
      2'h2:    lsw_div_mask = 3'h3;
      default: lsw_div_mask = 3'h7;
    endcase
  endfunction

endpackage

// *** verilog/lsw_tick_gen.sv ***
// measurement tick generator: divided system clock or byte clock ticks
`timescale 1ns/1ps
module lsw_tick_gen
  import lsw_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       source_sel,
  input  wire logic [1:0] divide,
  input  wire logic       byte_clock_tick,
  output logic            tick
);

  logic [2:0] div_count;
  logic [2:0] mask;

  assign mask = lsw_div_mask(divide);
  // divider only acts on the internal source [RQ3] [RQ4] [RQ8]
  assign tick = run && (source_sel ? byte_clock_tick : (div_count == mask));

  always_ff @(posedge clock) begin
    if (rst || !run || source_sel) begin
      div_count <= LSW_DIV_RESET;
    end else if (div_count == mask) begin
      div_count <= LSW_DIV_RESET;
    end else begin
      div_count <= div_count + 3'h1;
    end
  end

  // next tick lands eight clocks after the last one
  chk_div_period: assert property ( // [RQ3]
    @(posedge clock) disable iff (rst)
    (run && !source_sel && divide == 2'h3 && tick) ##1
    (run && !source_sel && divide == 2'h3)[*8] |-> tick)
    else $error("divide by 8 tick spacing wrong");

  chk_byte_source: assert property ( // [RQ4]
    @(posedge clock) disable iff (rst)
    (run && source_sel) |-> (tick == byte_clock_tick))
    else $error("byte clock source not followed");

endmodule

// *** verilog/lsw_stopwatch.sv ***
// latency stopwatch: control register, event select, counter, readout
`timescale 1ns/1ps
// How it works
// RQ1 - start select 00 is low speed rx, 01 high speed tx, 1x marker rise.
// RQ2 - stop select 00 is low speed tx, 01 high speed rx, 1x marker fall.
// RQ3 - the clock divide field divides the measurement clock by 1, 2, 4 or 8.
// RQ4 - the divide field acts only while the clock source bit is zero.
// RQ5 - software keeps the measurement clock no slower than the byte clock.
// RQ6 - the enable bit turns measurement on when 1 and off when 0.
// RQ7 - the control register is all zeros after reset.
// RQ8 - bit 0 picks the divided internal clock (0) or the byte clock (1).
// RQ9 - the 20-bit count is in half periods, starts at zero and saturates.
// RQ10 - a latched ready flag marks a finished measurement.
// RQ11 - reading the clear address zeroes the count, comma flags and ready.
// RQ12 - while enabled counting runs from start to stop and the count holds.
module lsw_stopwatch
  import lsw_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic [3:0]  ls_rx_comma,
  input  wire logic [1:0]  hs_tx_comma,
  input  wire logic [3:0]  ls_tx_comma,
  input  wire logic [1:0]  hs_rx_comma,
  input  wire logic        ext_marker_pin,
  input  wire logic        byte_clock_tick,
  output logic             stopwatch_result_valid,
  output logic             stopwatch_busy
);

  logic [7:0]  control;
  logic [1:0]  stopwatch_start_select;
  logic [1:0]  stopwatch_stop_select;
  logic [1:0]  stopwatch_clock_divide;
  logic        stopwatch_enable;
  logic        clock_source;
  logic [19:0] stopwatch_count;
  logic [3:0]  start_comma;
  logic [3:0]  stop_comma;
  logic        marker_prev;
  logic        marker_rise;
  logic        marker_fall;
  logic        start_hit;
  logic        stop_hit;
  logic [3:0]  start_lanes;
  logic [3:0]  stop_lanes;
  logic        clear_read;
  logic        tick;
  logic        start_take;
  logic        stop_take;
  lsw_state_e  state;
  lsw_state_e  next_state;

  assign stopwatch_start_select = control[LSW_START_LSB +: 2];
  assign stopwatch_stop_select  = control[LSW_STOP_LSB +: 2];
  assign stopwatch_clock_divide = control[LSW_DIV_LSB +: 2];
  assign stopwatch_enable       = control[LSW_ENABLE_BIT];
  assign clock_source           = control[LSW_SOURCE_BIT];

  assign marker_rise = ext_marker_pin && !marker_prev;
  assign marker_fall = !ext_marker_pin && marker_prev;
  assign clear_read  = reg_rd && (reg_addr == LSW_ADDR_CLEAR);

  // start event mux [RQ1]
  always_comb begin
    if (stopwatch_start_select[1]) begin
      start_lanes = {3'h0, marker_rise};
    end else if (stopwatch_start_select == LSW_SEL_HIGH) begin
      start_lanes = {2'h0, hs_tx_comma};
    end else begin
      start_lanes = ls_rx_comma;
    end
    start_hit = |start_lanes;
  end

  // stop event mux [RQ2]
  always_comb begin
    if (stopwatch_stop_select[1]) begin
      stop_lanes = {3'h0, marker_fall};
    end else if (stopwatch_stop_select == LSW_SEL_HIGH) begin
      stop_lanes = {2'h0, hs_rx_comma};
    end else begin
      stop_lanes = ls_tx_comma;
    end
    stop_hit = |stop_lanes;
  end

  assign start_take = stopwatch_enable && (state == LSW_IDLE) && start_hit;
  assign stop_take  = stopwatch_enable && (state == LSW_RUN) && stop_hit;

  lsw_tick_gen u_tick (
    .clock           (clock),
    .rst             (rst),
    .run             (state == LSW_RUN),
    .source_sel      (clock_source),
    .divide          (stopwatch_clock_divide),
    .byte_clock_tick (byte_clock_tick),
    .tick            (tick)
  );

  // control register
  always_ff @(posedge clock) begin
    if (rst) begin
      control <= LSW_CONTROL_RESET; // [RQ7]
    end else if (reg_wr && reg_addr == LSW_ADDR_CONTROL) begin
      control <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      marker_prev <= 1'b0;
    end else begin
      marker_prev <= ext_marker_pin;
    end
  end

  // measurement sequence
  always_comb begin
    next_state = state;
    if (!stopwatch_enable) begin
      next_state = LSW_IDLE; // [RQ6]
    end else begin
      case (state)
        LSW_IDLE: begin
          if (start_hit) begin
            next_state = LSW_RUN; // [RQ12]
          end
        end
        LSW_RUN: begin
          if (stop_hit) begin
            next_state = LSW_DONE; // [RQ12]
          end else if (clear_read) begin
            next_state = LSW_IDLE;
          end
        end
        LSW_DONE: begin
          if (clear_read) begin
            next_state = LSW_IDLE; // [RQ11]
          end
        end
        default: next_state = LSW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state          <= LSW_IDLE;
      stopwatch_busy <= 1'b0;
    end else begin
      state          <= next_state;
      stopwatch_busy <= (next_state == LSW_RUN);
    end
  end

  // half-period counter, saturating [RQ9]
  always_ff @(posedge clock) begin
    if (rst) begin
      stopwatch_count <= LSW_COUNT_RESET;
    end else if (start_take) begin
      stopwatch_count <= LSW_COUNT_RESET;
    end else if (stopwatch_enable && state == LSW_RUN) begin
      if (clear_read && !stop_hit) begin
        stopwatch_count <= LSW_COUNT_RESET; // [RQ11]
      end else if (tick && stopwatch_count != LSW_COUNT_MAX) begin
        stopwatch_count <= stopwatch_count + 20'h00001; // [RQ9]
      end
    end else if (clear_read) begin
      stopwatch_count <= LSW_COUNT_RESET; // [RQ11]
    end
  end

  // sticky flags, a set in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (rst) begin
      stopwatch_result_valid <= 1'b0;
      start_comma            <= 4'h0;
      stop_comma             <= 4'h0;
    end else begin
      stopwatch_result_valid <= (stopwatch_result_valid && !clear_read)
                                || stop_take; // [RQ10] [RQ11]
      start_comma <= (clear_read ? 4'h0 : start_comma)
                     | (start_take ? start_lanes : 4'h0);
      stop_comma  <= (clear_read ? 4'h0 : stop_comma)
                     | (stop_take ? stop_lanes : 4'h0);
    end
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == LSW_ADDR_CONTROL) begin
        reg_rdata <= {8'h00, control};
      end else if (reg_addr == LSW_ADDR_COUNT_HI) begin
        reg_rdata <= {start_comma, stop_comma, 3'h0,
                      stopwatch_result_valid, stopwatch_count[19:16]};
      end else if (reg_addr == LSW_ADDR_COUNT_LO) begin
        reg_rdata <= stopwatch_count[15:0];
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  chk_control_reset: assert property ( // [RQ7]
    @(posedge clock)
    rst |=> (control == LSW_CONTROL_RESET))
    else $error("control not zero after reset");

  chk_start_rise: assert property ( // [RQ1]
    @(posedge clock) disable iff (rst)
    (stopwatch_enable && state == LSW_IDLE && stopwatch_start_select[1]
     && marker_rise) |=> (state == LSW_RUN && stopwatch_count == 20'h0))
    else $error("marker rise did not start");

  chk_start_low: assert property ( // [RQ1]
    @(posedge clock) disable iff (rst)
    (stopwatch_enable && state == LSW_IDLE && stopwatch_start_select == 2'h0
     && (|ls_rx_comma)) |=> (state == LSW_RUN && |start_comma))
    else $error("low speed receive did not start");

  chk_stop_fall: assert property ( // [RQ2]
    @(posedge clock) disable iff (rst)
    (stopwatch_enable && state == LSW_RUN && stopwatch_stop_select[1]
     && marker_fall) |=> (stopwatch_result_valid && state == LSW_DONE))
    else $error("marker fall did not stop");

  chk_disable_idle: assert property ( // [RQ6]
    @(posedge clock) disable iff (rst)
    !stopwatch_enable |=> (state == LSW_IDLE && !stopwatch_busy))
    else $error("disabled stopwatch not idle");

  chk_count_step: assert property ( // [RQ9]
    @(posedge clock) disable iff (rst)
    (stopwatch_enable && state == LSW_RUN && tick && !clear_read
     && stopwatch_count != LSW_COUNT_MAX)
    |=> stopwatch_count == $past(stopwatch_count) + 20'h00001)
    else $error("count did not step on tick");

  chk_count_sat: assert property ( // [RQ9]
    @(posedge clock) disable iff (rst)
    (state == LSW_RUN && stopwatch_count == LSW_COUNT_MAX && !clear_read)
    |=> stopwatch_count == LSW_COUNT_MAX)
    else $error("count wrapped past saturation");

  chk_clear_read: assert property ( // [RQ11]
    @(posedge clock) disable iff (rst)
    (clear_read && !start_take && !stop_take) |=>
    (!stopwatch_result_valid && stopwatch_count == 20'h0
     && start_comma == 4'h0 && stop_comma == 4'h0))
    else $error("clear read left state behind");

  chk_hold_done: assert property ( // [RQ12]
    @(posedge clock) disable iff (rst)
    (state == LSW_DONE && !clear_read && !start_take) |=>
    $stable(stopwatch_count))
    else $error("finished count moved");

endmodule

// *** test/lsw_host.sv ***
// host model: writes and reads of the stopwatch registers
`timescale 1ns/1ps
module lsw_host (
  input  wire logic        clock,
  output logic      [15:0] reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr  = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end
  // strobe held across exactly one rising edge, then data scrambled
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask
  // data is registered at the read edge and taken half a cycle later
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clock);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask
endmodule

// *** test/lsw_stopwatch_test.sv ***
// self-checking bench for the latency stopwatch
`timescale 1ns/1ps
`define CHK(g, e) check_val(g, e)
module lsw_stopwatch_test;
  import lsw_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  wire  [15:0] reg_addr;
  wire         reg_wr;
  wire         reg_rd;
  wire  [15:0] reg_wdata;
  wire  [15:0] reg_rdata;
  logic [3:0]  ls_rx_comma = 4'h0;
  logic [1:0]  hs_tx_comma = 2'h0;
  logic [3:0]  ls_tx_comma = 4'h0;
  logic [1:0]  hs_rx_comma = 2'h0;
  logic        ext_marker_pin = 1'b0;
  logic        byte_clock_tick = 1'b0;
  logic [2:0]  bt_cnt = 3'h0;
  wire         stopwatch_result_valid;
  wire         stopwatch_busy;
  int          n_mismatch = 0;
  int          n_compared = 0;

  lsw_stopwatch dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .ls_rx_comma(ls_rx_comma),
    .hs_tx_comma(hs_tx_comma), .ls_tx_comma(ls_tx_comma),
    .hs_rx_comma(hs_rx_comma), .ext_marker_pin(ext_marker_pin),
    .byte_clock_tick(byte_clock_tick),
    .stopwatch_result_valid(stopwatch_result_valid),
    .stopwatch_busy(stopwatch_busy));
  lsw_host host_u (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  always #50 clock = ~clock;
  // byte clock half period of eight system clocks, as slow as divide by 8
  always @(negedge clock) begin
    bt_cnt          <= bt_cnt + 3'h1;
    byte_clock_tick <= (bt_cnt == 3'h7);
  end

  task automatic check_val(input logic [19:0] g, input logic [19:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one-cycle comma pulse, or a marker level change
  task automatic event_pulse(input logic [1:0] sel, input logic start);
    @(negedge clock);
    if (sel[1]) ext_marker_pin = start;
    else if (start) {hs_tx_comma, ls_rx_comma} = sel[0] ? 6'h10 : 6'h08;
    else {hs_rx_comma, ls_tx_comma} = sel[0] ? 6'h10 : 6'h01;
    @(negedge clock);
    {hs_tx_comma, ls_rx_comma, hs_rx_comma, ls_tx_comma} = 12'h000;
  endtask

  task automatic measure(input logic [1:0] st, input logic [1:0] sp,
                         input logic [1:0] dv, input logic src,
                         input logic [19:0] exp);
    logic [15:0] d;
    logic [19:0] cnt;
    host_u.wr(LSW_ADDR_CONTROL, {8'h00, st, dv, sp, 1'b1, src});
    if (sp[1] && !st[1]) ext_marker_pin = 1'b1;
    event_pulse(st, 1'b1);
    repeat (47) @(negedge clock);
    event_pulse(sp, 1'b0);
    `CHK({18'h0, stopwatch_result_valid, stopwatch_busy}, 20'h2);
    host_u.rd(LSW_ADDR_COUNT_HI, d);
    `CHK({15'h0, d[4], 4'h0}, 20'h10);
    `CHK({18'h0, |d[15:12], |d[11:8]}, 20'h3);
    cnt[19:16] = d[3:0];
    host_u.rd(LSW_ADDR_COUNT_LO, d);
    cnt[15:0] = d;
    `CHK({19'h0, cnt + 20'h1 >= exp && cnt <= exp + 20'h1}, 20'h1);
    host_u.rd(LSW_ADDR_CLEAR, d);
    `CHK({4'h0, d}, 20'h0);
    host_u.rd(LSW_ADDR_COUNT_HI, d);
    `CHK({4'h0, d}, 20'h0);
    host_u.rd(LSW_ADDR_COUNT_LO, d);
    `CHK({3'h0, d, stopwatch_result_valid}, 20'h0);
    ext_marker_pin = 1'b0;
  endtask

  task automatic t_reset;
    logic [15:0] d;
    logic [15:0] addrs [4];
    addrs = '{LSW_ADDR_CONTROL, LSW_ADDR_COUNT_HI, LSW_ADDR_COUNT_LO,
              16'h8030};
    foreach (addrs[i]) begin
      host_u.rd(addrs[i], d);
      `CHK({4'h0, d}, 20'h0);
    end
    `CHK({18'h0, stopwatch_result_valid, stopwatch_busy}, 20'h0);
  endtask

  task automatic t_control;
    logic [15:0] d;
    host_u.wr(LSW_ADDR_CONTROL, 16'hFFFD);
    host_u.rd(LSW_ADDR_CONTROL, d);
    `CHK({4'h0, d}, 20'h000FD);
    host_u.wr(16'h8041, 16'hFFFF);
    host_u.rd(LSW_ADDR_COUNT_HI, d);
    `CHK({4'h0, d}, 20'h0);
    host_u.wr(LSW_ADDR_CONTROL, 16'h0000);
  endtask

  task automatic t_select;
    for (int s = 0; s < 4; s++)
      for (int p = 0; p < 4; p++)
        measure(2'(s), 2'(p), 2'h0, 1'b0, 20'h30);
  endtask

  // no divided clock here is slower than the byte clock
  task automatic t_divide;
    for (int v = 0; v < 4; v++)
      measure(2'h0, 2'h1, 2'(v), 1'b0, 20'(20'h30 >> v));
  endtask

  // divide code 0 would count every clock if it were not ignored
  task automatic t_source;
    measure(2'h1, 2'h0, 2'h0, 1'b1, 20'h06);
  endtask

  task automatic t_disabled;
    logic [15:0] d;
    host_u.wr(LSW_ADDR_CONTROL, 16'h0000);
    event_pulse(2'h0, 1'b1);
    `CHK({19'h0, stopwatch_busy}, 20'h0);
    event_pulse(2'h0, 1'b0);
    host_u.rd(LSW_ADDR_COUNT_HI, d);
    `CHK({3'h0, d, stopwatch_result_valid}, 20'h0);
  endtask

  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    t_reset();
    t_control();
    t_select();
    t_divide();
    t_source();
    t_disabled();
    finish_test();
  end

  initial begin
    #2000000;
    n_mismatch++;
    finish_test();
  end
endmodule
